// >>> logic/usb_err_regs.svh
// Register offsets, field positions and reset values of the USB error status block
`ifndef USB_ERR_REGS_SVH
`define USB_ERR_REGS_SVH

`define ERR_FLAGS_OFFSET   4'h0
`define ERR_ENABLE_OFFSET  4'h4
`define ERR_CONTROL_OFFSET 4'h8

`define BIT_STUFF          7
`define BIT_OVERRUN        5
`define BIT_TURNAROUND     4
`define BIT_DATA_LENGTH    3
`define BIT_DATA_CRC       2
`define BIT_TOKEN_FRAME    1
`define BIT_PID            0

`define IMPL_MASK          8'hBF
`define FLAGS_RESET        8'h00
`define ENABLE_RESET       8'h00
`define CONTROL_RESET      1'h0

`endif

// >>> logic/usb_err_pkg.sv
// Types shared by the USB error status block
package usb_err_pkg;
  typedef logic [7:0]  err_byte_t;
  typedef logic [15:0] reg_word_t;
  typedef logic [3:0]  reg_addr_t;
endpackage : usb_err_pkg

// >>> logic/sticky_flag.sv
// One hardware-set, write-one-to-clear sticky flag
`timescale 1ns/1ps
module sticky_flag (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag_r
);
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (clr_req) begin
      flag_r <= 1'b0;
    end
  end
endmodule : sticky_flag

// >>> logic/overrun_guard.sv
// Truncates received bytes beyond the descriptor byte count and flags the excess
`timescale 1ns/1ps
module overrun_guard (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       pkt_start,
  input  wire logic [9:0] desc_byte_count,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  output logic            mem_wr_en,
  output logic [7:0]      mem_wr_data,
  output logic            overrun_evt
);
  logic [9:0] stored_r;
  logic       room;

  // Room left while fewer than the allowed count have been stored
  assign room        = (stored_r < desc_byte_count);
  assign mem_wr_en   = rx_byte_valid && (room || pkt_start) && (desc_byte_count != 10'h000);
  // Any byte not stored is excess, even the first one of a zero-count packet
  assign overrun_evt = rx_byte_valid && !mem_wr_en;
  assign mem_wr_data = rx_byte;

  // Count of stored bytes restarts with each packet
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_r <= 10'h000;
    end else if (pkt_start) begin
      stored_r <= mem_wr_en ? 10'h001 : 10'h000;
    end else if (mem_wr_en) begin
      stored_r <= stored_r + 10'h001;
    end
  end
endmodule : overrun_guard

// >>> logic/usb_error_status.sv
// USB error status flags with enable register and error-condition output
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "usb_err_regs.svh"
module usb_error_status
  import usb_err_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire reg_addr_t  reg_addr,
  input  wire reg_word_t  reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output reg_word_t       reg_rdata,
  input  wire logic       stuff_err_evt,
  input  wire logic       turnaround_timeout_evt,
  input  wire logic       data_end_evt,
  input  wire logic [2:0] data_bit_residue,
  input  wire logic       data_crc_done,
  input  wire logic       data_crc_ok,
  input  wire logic       token_crc_done,
  input  wire logic       token_crc_ok,
  input  wire logic       frame_end_violation_evt,
  input  wire logic       pid_done,
  input  wire logic [7:0] pid_field,
  input  wire logic       pkt_start,
  input  wire logic [9:0] desc_byte_count,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  output logic            mem_wr_en,
  output logic [7:0]      mem_wr_data,
  output logic            token_reject,
  output logic            host_mode,
  output logic            error_condition
);
  err_byte_t  enable_r;
  logic       host_mode_r;
  err_byte_t  set_vec;
  err_byte_t  clr_vec;
  err_byte_t  flags;
  logic       overrun_evt;
  logic       flags_wr;

  // Byte-count guard on the receive path
  overrun_guard u_guard (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .pkt_start       (pkt_start),
    .desc_byte_count (desc_byte_count),
    .rx_byte_valid   (rx_byte_valid),
    .rx_byte         (rx_byte),
    .mem_wr_en       (mem_wr_en),
    .mem_wr_data     (mem_wr_data),
    .overrun_evt     (overrun_evt)
  );

  // Hardware events mapped onto flag positions
  always_comb begin
    set_vec                   = 8'h00;
    set_vec[`BIT_STUFF]       = stuff_err_evt;
    set_vec[`BIT_OVERRUN]     = overrun_evt;
    set_vec[`BIT_TURNAROUND]  = turnaround_timeout_evt;
    set_vec[`BIT_DATA_LENGTH] = data_end_evt && (data_bit_residue != 3'h0);
    set_vec[`BIT_DATA_CRC]    = data_crc_done && !data_crc_ok;
    // Bit 1 source follows the mode; the other source is ignored
    set_vec[`BIT_TOKEN_FRAME] = host_mode_r ? frame_end_violation_evt
                                            : (token_crc_done && !token_crc_ok);
    set_vec[`BIT_PID]         = pid_done && (pid_field[7:4] != ~pid_field[3:0]);
  end

  // Token rejection only meaningful in device mode
  assign token_reject = !host_mode_r && token_crc_done && !token_crc_ok;

  // Whole-word write of ones clears; zeros leave flags alone
  assign flags_wr = reg_wr && (reg_addr == `ERR_FLAGS_OFFSET);
  assign clr_vec  = flags_wr ? (reg_wdata[7:0] & `IMPL_MASK) : 8'h00;

  // One sticky cell per implemented position; bit 6 has none
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      if (g == 6) begin : g_none
        assign flags[g] = 1'b0;
      end else begin : g_cell
        sticky_flag u_flag (
          .core_clk (core_clk),
          .rst_n    (rst_n),
          .set_evt  (set_vec[g]),
          .clr_req  (clr_vec[g]),
          .flag_r   (flags[g])
        );
      end
    end
  endgenerate

  // Enable register, same layout as the flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= `ENABLE_RESET;
    end else if (reg_wr && reg_addr == `ERR_ENABLE_OFFSET) begin
      enable_r <= reg_wdata[7:0] & `IMPL_MASK;
    end
  end

  // Mode control, selects meaning of bit 1
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_mode_r <= `CONTROL_RESET;
    end else if (reg_wr && reg_addr == `ERR_CONTROL_OFFSET) begin
      host_mode_r <= reg_wdata[0];
    end
  end
  assign host_mode = host_mode_r;

  // Combined error indication for the top-level interrupt status
  assign error_condition = |(flags & enable_r);

  // Read data valid the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ERR_FLAGS_OFFSET:   reg_rdata <= {8'h00, flags};
        `ERR_ENABLE_OFFSET:  reg_rdata <= {8'h00, enable_r};
        `ERR_CONTROL_OFFSET: reg_rdata <= {15'h0000, host_mode_r};
        default:             reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // A set event holds its flag at one in the next cycle despite a clear
  stuff_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stuff_err_evt |=> flags[`BIT_STUFF])
    else $error("stuffing flag not set");

  // Bit 6 and the upper byte never read back as one
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(reg_rd) |-> (reg_rdata[15:8] == 8'h00 && !reg_rdata[6]))
    else $error("reserved bits read nonzero");

  // A flag read returns the flags as they stood at the strobe
  flags_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(reg_rd) && $past(reg_addr) == `ERR_FLAGS_OFFSET)
      |-> (reg_rdata[7:0] == $past(flags)))
    else $error("flag read differs from flags");

  // Overrun never writes to memory
  overrun_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    overrun_evt |-> !mem_wr_en ##1 flags[`BIT_OVERRUN])
    else $error("excess byte stored or not flagged");

  // A zero byte count lets nothing into the buffer
  zero_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (desc_byte_count == 10'h000) |-> !mem_wr_en)
    else $error("byte stored with zero count");

  // Timeout flagged next cycle
  timeout_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    turnaround_timeout_evt |=> flags[`BIT_TURNAROUND])
    else $error("turnaround flag not set");

  // Partial byte at data end sets the length flag
  length_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (data_end_evt && data_bit_residue != 3'h0) |=> flags[`BIT_DATA_LENGTH])
    else $error("length flag not set");

  // Passing CRC with clear flag and no clear keeps it clear
  crc_pass_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!flags[`BIT_DATA_CRC] && !(data_crc_done && !data_crc_ok)) |=> !flags[`BIT_DATA_CRC])
    else $error("data crc flag set without failure");

  // Device mode token CRC failure sets bit 1
  token_crc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!host_mode_r && token_crc_done && !token_crc_ok) |=> flags[`BIT_TOKEN_FRAME])
    else $error("token crc flag not set");

  // Host mode frame-end violation sets bit 1
  frame_end_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (host_mode_r && frame_end_violation_evt) |=> flags[`BIT_TOKEN_FRAME])
    else $error("frame end flag not set");

  // Bad PID complement sets bit 0
  pid_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pid_done && pid_field[7:4] != ~pid_field[3:0]) |=> flags[`BIT_PID])
    else $error("pid flag not set");

  // Flags rise only after their own hardware event, never by a write
  stuff_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_STUFF]) |-> $past(set_vec[`BIT_STUFF]))
    else $error("stuffing flag rose without a violation");

  // Overrun flag only follows a dropped byte
  overrun_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_OVERRUN]) |-> $past(overrun_evt))
    else $error("overrun flag rose without excess");

  // Turnaround flag only follows a timeout
  timeout_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_TURNAROUND]) |-> $past(turnaround_timeout_evt))
    else $error("turnaround flag rose without timeout");

  // Length flag only follows a partial final byte
  length_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_DATA_LENGTH]) |-> $past(set_vec[`BIT_DATA_LENGTH]))
    else $error("length flag rose without residue");

  // Data CRC flag only follows a failed check
  crc_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_DATA_CRC]) |-> $past(set_vec[`BIT_DATA_CRC]))
    else $error("data crc flag rose without failure");

  // Bit 1 only follows the event of the current mode
  bit1_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_TOKEN_FRAME]) |-> $past(set_vec[`BIT_TOKEN_FRAME]))
    else $error("bit 1 rose without its event");

  // PID flag only follows a failed complement check
  pid_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags[`BIT_PID]) |-> $past(set_vec[`BIT_PID]))
    else $error("pid flag rose without failure");

  // A flag falls only after a written one at its position
  clear_by_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_STUFF]) |-> $past(clr_vec[`BIT_STUFF]))
    else $error("flag cleared without a written one");

  // Same for the overrun flag
  clear_overrun_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_OVERRUN]) |-> $past(clr_vec[`BIT_OVERRUN]))
    else $error("overrun flag cleared without a written one");

  // Same for the turnaround flag
  clear_turnaround_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_TURNAROUND]) |-> $past(clr_vec[`BIT_TURNAROUND]))
    else $error("turnaround flag cleared without a written one");

  // Same for the length flag
  clear_length_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_DATA_LENGTH]) |-> $past(clr_vec[`BIT_DATA_LENGTH]))
    else $error("length flag cleared without a written one");

  // Same for the data CRC flag
  clear_crc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_DATA_CRC]) |-> $past(clr_vec[`BIT_DATA_CRC]))
    else $error("data crc flag cleared without a written one");

  // Same for the shared bit 1, whichever mode set it
  clear_bit1_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_TOKEN_FRAME]) |-> $past(clr_vec[`BIT_TOKEN_FRAME]))
    else $error("bit 1 cleared without a written one");

  // Same for the PID flag
  clear_pid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flags[`BIT_PID]) |-> $past(clr_vec[`BIT_PID]))
    else $error("pid flag cleared without a written one");

  // A written one clears its flag when no event lands in the same cycle
  write_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flags_wr && reg_wdata[`BIT_PID] && !pid_done) |=> !flags[`BIT_PID])
    else $error("written one did not clear pid flag");

  // A written zero leaves a set flag alone
  zero_write_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flags_wr && !reg_wdata[`BIT_STUFF] && flags[`BIT_STUFF]) |=> flags[`BIT_STUFF])
    else $error("written zero cleared stuffing flag");

  // Host mode ignores token CRC failures for bit 1
  host_token_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (host_mode_r && !flags[`BIT_TOKEN_FRAME] && !frame_end_violation_evt)
      |=> !flags[`BIT_TOKEN_FRAME])
    else $error("bit 1 set in host mode without frame end error");

  // Device mode ignores frame-end events for bit 1
  device_frame_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!host_mode_r && !flags[`BIT_TOKEN_FRAME] && !token_crc_done)
      |=> !flags[`BIT_TOKEN_FRAME])
    else $error("bit 1 set in device mode without token check");

  // No token is rejected while acting as host
  token_host_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_mode_r |-> !token_reject)
    else $error("token rejected in host mode");

  // Error output tracks flags and enables
  error_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flags[`BIT_PID] && enable_r[`BIT_PID]) |-> error_condition)
    else $error("error condition missing");

  // Same for the stuffing flag at the top bit
  stuff_error_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flags[`BIT_STUFF] && enable_r[`BIT_STUFF]) |-> error_condition)
    else $error("error condition missing for stuffing flag");

  // With every enable off the output stays low whatever the flags
  error_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable_r == 8'h00) |-> !error_condition)
    else $error("error condition with all enables off");
endmodule : usb_error_status

// >>> bench/usb_bus_model.sv
// Far-side USB traffic source: error event pulses and received bytes
`timescale 1ns/1ps
module usb_bus_model (
  input  wire logic core_clk,
  output logic [6:0] ev,
  output logic [2:0] residue,
  output logic       crc_ok,
  output logic [7:0] pid_field,
  output logic       pkt_start,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte
);
  initial begin
    ev = 7'h00;
    residue = 3'h0;
    crc_ok = 1'b1;
    pid_field = 8'hA5;
    pkt_start = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // One event; qualifiers invert when idle so stale values differ from those of the event
  task automatic fire(input int k, input logic bad);
    @(posedge core_clk);
    ev <= 7'h01 << k;
    residue <= bad ? 3'h5 : 3'h0;
    crc_ok <= ~bad;
    pid_field <= bad ? 8'hA6 : 8'hA5;
    @(posedge core_clk);
    ev <= 7'h00;
    residue <= ~residue;
    crc_ok <= ~crc_ok;
    pid_field <= ~pid_field;
  endtask : fire
  // Back-to-back bytes of one packet
  task automatic packet(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      pkt_start <= (i == 0);
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'h10 + 8'(i);
    end
    @(posedge core_clk);
    pkt_start <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask : packet
endmodule : usb_bus_model

// >>> bench/tb.sv
// Self-checking bench for the USB error status block
`timescale 1ns/1ps
module tb;
  import usb_err_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  reg_addr_t  reg_addr = 4'h0;
  reg_word_t  reg_wdata = 16'h0000;
  reg_word_t  reg_rdata, exp;
  logic [6:0] ev;
  logic [2:0] residue;
  logic [7:0] pid_field, rx_byte, mem_wr_data;
  logic [9:0] desc_byte_count = 10'h002;
  logic       crc_ok, pkt_start, rx_byte_valid, mem_wr_en, token_reject, host_mode, err_out;
  int         fails = 0;
  int         checks_done = 0;
  int         stored = 0;
  int         rejects = 0;
  int         bit_of[7] = '{7, 4, 3, 2, 1, 1, 0};
  always #12.5 core_clk = ~core_clk;
  usb_bus_model u_bus (.core_clk(core_clk), .ev(ev), .residue(residue), .crc_ok(crc_ok),
    .pid_field(pid_field), .pkt_start(pkt_start), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte));
  usb_error_status u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stuff_err_evt(ev[0]), .turnaround_timeout_evt(ev[1]), .data_end_evt(ev[2]),
    .data_bit_residue(residue), .data_crc_done(ev[3]), .data_crc_ok(crc_ok),
    .token_crc_done(ev[4]), .token_crc_ok(crc_ok), .frame_end_violation_evt(ev[5]),
    .pid_done(ev[6]), .pid_field(pid_field), .pkt_start(pkt_start),
    .desc_byte_count(desc_byte_count), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .token_reject(token_reject),
    .host_mode(host_mode), .error_condition(err_out));
  // Count bytes let into the buffer; stored data must be the received byte
  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1) begin
      check("stored byte", 16'h0010 + 16'(stored), {8'h00, mem_wr_data});
      stored <= stored + 1;
    end
    if (token_reject === 1'b1) rejects <= rejects + 1;
  end
  task automatic check(string what, reg_word_t e, reg_word_t got);
    checks_done++;
    if (got !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic wr(reg_addr_t a, reg_word_t d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(reg_addr_t a, reg_word_t e, string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(what, e, reg_rdata);
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Tests take about 120 cycles; the 4000-cycle limit, over thirty times that, means a hang
  initial begin
    #(25 * 4000);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0000, "flags after reset");
    wr(4'h4, 16'hFFFF);
    rd(4'h4, 16'h00BF, "enable register");
    rd(4'hC, 16'h0000, "unmapped read");
    for (int k = 2; k < 7; k++) u_bus.fire(k, 1'b0);
    rd(4'h0, 16'h0000, "flags after good packets");
    $display("test reset and clean traffic done");
    exp = 16'h0000;
    for (int k = 0; k < 7; k++) begin
      u_bus.fire(k, 1'b1);
      if (k != 5) exp[bit_of[k]] = 1'b1;
      rd(4'h0, exp, "flags after error event");
    end
    check("error output", 16'h0001, {15'h0000, err_out});
    wr(4'h0, 16'hFF40);
    rd(4'h0, exp, "flags after zero write");
    wr(4'h4, 16'h0020);
    check("masked error output", 16'h0000, {15'h0000, err_out});
    for (int b = 7; b >= 0; b--) begin
      wr(4'h0, 16'(1 << b));
      exp[b] = 1'b0;
      rd(4'h0, exp, "flags after single clear");
    end
    wr(4'h4, 16'h0001);
    u_bus.fire(6, 1'b1);
    #1 check("enabled error output", 16'h0001, {15'h0000, err_out});
    wr(4'h0, 16'h0001);
    $display("test set and clear done");
    wr(4'h8, 16'h0001);
    check("host mode", 16'h0001, {15'h0000, host_mode});
    rd(4'h8, 16'h0001, "control readback");
    u_bus.fire(4, 1'b1);
    u_bus.fire(5, 1'b1);
    rd(4'h0, 16'h0002, "host mode bit 1");
    wr(4'h0, 16'h0002);
    wr(4'h8, 16'h0000);
    $display("test host mode done");
    u_bus.packet(3);
    check("bytes stored", 16'h0002, 16'(stored));
    rd(4'h0, 16'h0020, "overrun flag");
    check("token rejects", 16'h0001, 16'(rejects));
    $display("test overrun done");
    wrap_up();
  end
endmodule : tb
